// ==== vprf_pkg.sv ====
package vprf_pkg;

  // ***********************************************************
  // Speed parameters
  // ***********************************************************
  typedef logic [18:0] vprf_spd_t;
  localparam vprf_spd_t SPD_MIN   = 19'h0_0001;
  localparam vprf_spd_t SPD_MAX   = 19'h7_A120;
  localparam vprf_spd_t RUN_RST   = 19'h0_03E8;
  localparam vprf_spd_t SEG_RST   = 19'h0_03E8;
  localparam vprf_spd_t START_RST = 19'h0_0064;
  localparam logic      DETAIL_RST = 1'b1;
  localparam int        NSEG      = 4;
  localparam int        VEL_W     = 20;

  // ***********************************************************
  // Timing
  // ***********************************************************
  localparam int CLK_HZ      = 50_000_000;
  localparam int TICK_US     = 1000;
  localparam int TICK_CYC    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int TIME_W      = 16;

  // ***********************************************************
  // Items, requests and persistent image
  // ***********************************************************
  typedef enum logic [2:0] {
    IT_RUN    = 3'h0,
    IT_SEG0   = 3'h1,
    IT_SEG1   = 3'h2,
    IT_SEG2   = 3'h3,
    IT_SEG3   = 3'h4,
    IT_START  = 3'h5,
    IT_DETAIL = 3'h6,
    IT_VNOW   = 3'h7
  } vprf_item_e;

  typedef enum logic [1:0] {
    RQ_QUERY   = 2'h0,
    RQ_VIEW    = 2'h1,
    RQ_VERSION = 2'h2
  } vprf_kind_e;

  typedef struct packed {
    vprf_kind_e kind;
    vprf_item_e item;
    logic       from_seq;
  } vprf_req_s;

  typedef struct packed {
    vprf_spd_t            run;
    vprf_spd_t            start;
    vprf_spd_t [NSEG-1:0] seg;
  } vprf_speeds_s;

  typedef struct packed {
    vprf_speeds_s spd;
    logic         detail;
    logic [6:0]   valid;
  } vprf_nv_s;

  localparam int NV_SPEEDS = 0;
  localparam int NV_DETAIL = 1;

  // ***********************************************************
  // State machines
  // ***********************************************************
  typedef enum logic [2:0] {
    RP_IDLE = 3'b001,
    RP_RUN  = 3'b010,
    RP_STOP = 3'b100
  } vprf_ramp_e;

  typedef enum logic [7:0] {
    TX_IDLE   = 8'b0000_0001,
    TX_NAME   = 8'b0000_0010,
    TX_EQ     = 8'b0000_0100,
    TX_VAL    = 8'b0000_1000,
    TX_CR     = 8'b0001_0000,
    TX_LF     = 8'b0010_0000,
    TX_PROMPT = 8'b0100_0000,
    TX_FWID   = 8'b1000_0000
  } vprf_tx_e;

  // ***********************************************************
  // Reply characters
  // ***********************************************************
  localparam logic [7:0] CH_CR     = 8'h0D;
  localparam logic [7:0] CH_LF     = 8'h0A;
  localparam logic [7:0] CH_PROMPT = 8'h3E;
  localparam logic [7:0] CH_EQ     = 8'h3D;
  localparam logic [7:0] CH_MINUS  = 8'h2D;
  localparam logic [7:0] CH_ZERO   = 8'h30;
  localparam logic [7:0] CH_NAME0  = 8'h56;
  localparam logic [7:0] CH_RUN    = 8'h52;
  localparam logic [7:0] CH_START  = 8'h53;
  localparam logic [7:0] CH_DETAIL = 8'h42;
  localparam logic [7:0] CH_VNOW   = 8'h43;
  localparam int         FWID_LEN  = 24;
  localparam int         NDIG      = 7;

endpackage

// ==== vprf_dec.sv ====
`timescale 1ns/10ps
module vprf_dec
(
  // Value in
  input  wire logic signed [vprf_pkg::VEL_W-1:0] i_val,
  // Decimal digits out
  output logic [vprf_pkg::NDIG-1:0][3:0]         o_dig,
  output logic                                   o_neg,
  output logic [2:0]                             o_ndig
);
  import vprf_pkg::*;

  logic [VEL_W-1:0] mag;

  assign o_neg = i_val[VEL_W-1];
  assign mag   = o_neg ? VEL_W'(-i_val) : VEL_W'(i_val);

  // ***********************************************************
  // One divider per digit
  // ***********************************************************
  genvar k;
  generate
    for (k = 0; k < NDIG; k++)
    begin : g_dig
      localparam logic [VEL_W-1:0] POW = VEL_W'(10 ** k);
      assign o_dig[k] = 4'((mag / POW) % 20'h0_000A);
    end
  endgenerate

  // Count of significant digits, at least one
  always_comb
  begin
    o_ndig = 3'h1;
    for (int i = 1; i < NDIG; i++)
    begin
      if (o_dig[i] != 4'h0)
      begin
        o_ndig = 3'(i + 1);
      end
    end
  end

endmodule

// ==== vprf_ramp.sv ====
`timescale 1ns/10ps
module vprf_ramp
#(
  parameter int TICK_CYC = vprf_pkg::TICK_CYC
)
(
  // Clock and reset
  input  wire logic                                i_clk,
  input  wire logic                                i_rst_b,
  // Motion control
  input  wire logic                                i_start,
  input  wire logic                                i_dir,
  input  wire logic                                i_stop,
  input  wire vprf_pkg::vprf_spd_t                 i_target,
  input  wire vprf_pkg::vprf_spd_t                 i_start_spd,
  input  wire logic [vprf_pkg::TIME_W-1:0]         i_accel_ms,
  input  wire logic [vprf_pkg::TIME_W-1:0]         i_decel_ms,
  // Profile out
  output logic signed [vprf_pkg::VEL_W-1:0]        o_vel,
  output logic                                     o_moving
);
  import vprf_pkg::*;

  vprf_ramp_e        state;
  vprf_spd_t         mag;
  logic              dir;
  logic [19:0]       err;
  logic [15:0]       cnt;
  wire               tick = (cnt == 16'(TICK_CYC - 1));
  vprf_spd_t         top_spd;
  vprf_spd_t         goal;
  vprf_spd_t         span;
  wire               rising = (mag < goal);
  wire [TIME_W-1:0]  t = rising ? i_accel_ms : i_decel_ms;
  wire               jump = (t == '0) || (span == '0);
  vprf_spd_t         step;
  logic [19:0]       rem;
  logic [19:0]       sum;
  wire               carry = !jump && (sum >= 20'(t));
  logic [19:0]       inc;
  logic [19:0]       up;
  vprf_spd_t         next_mag;

  // ***********************************************************
  // Linear ramp between starting and running speed
  // ***********************************************************
  assign top_spd = (i_target > i_start_spd) ? i_target : i_start_spd;
  assign goal    = (state == RP_STOP) ? i_start_spd : top_spd;
  assign span    = top_spd - i_start_spd;
  assign step    = jump ? span : 19'(span / 19'(t));
  assign rem     = jump ? 20'h0_0000 : 20'(span % 19'(t));
  assign sum     = err + rem;
  assign inc     = 20'(step) + 20'(carry);
  assign up      = 20'(mag) + inc;
  assign next_mag = jump ? goal :
                    rising ? ((up >= 20'(goal)) ? goal : 19'(up)) :
                    ((20'(mag) <= 20'(goal) + inc) ? goal :
                     19'(20'(mag) - inc));

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt <= 16'h0000;
    end
    else
    begin
      cnt <= tick ? 16'h0000 : cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state <= RP_IDLE;
      mag   <= 19'h0_0000;
      dir   <= 1'b0;
      err   <= 20'h0_0000;
    end
    else
    begin
      case (state)
        RP_IDLE:
        begin
          if (i_start)
          begin
            state <= RP_RUN;
            mag   <= i_start_spd;
            dir   <= i_dir;
            err   <= 20'h0_0000;
          end
        end
        RP_RUN, RP_STOP:
        begin
          if (state == RP_RUN && i_stop)
          begin
            state <= RP_STOP;
            err   <= 20'h0_0000;
          end
          else if (tick && mag != goal)
          begin
            mag <= next_mag;
            err <= carry ? sum - 20'(t) : sum;
          end
          else if (tick && state == RP_STOP)
          begin
            state <= RP_IDLE;
            mag   <= 19'h0_0000;
          end
        end
        default:
        begin
          state <= RP_IDLE;
        end
      endcase
    end
  end

  // Signed command, sign gives direction
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_vel    <= 20'sh0_0000;
      o_moving <= 1'b0;
    end
    else
    begin
      o_vel    <= dir ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
      o_moving <= (state != RP_IDLE);
    end
  end

endmodule

// ==== vprf_top.sv ====
`timescale 1ns/10ps
module vprf_top
#(
  parameter int TICK_CYC = vprf_pkg::TICK_CYC,
  // Arbitrary identification text
  parameter logic [8*vprf_pkg::FWID_LEN-1:0] FW_TEXT =
    "X000 V.0.00 / 2000-01-01"
)
(
  // Clock and reset
  input  wire logic                         I_REF_CLK,
  input  wire logic                         I_RST_B,
  // Parameter writes
  input  wire logic                         I_WR,
  input  wire vprf_pkg::vprf_item_e         I_WR_ITEM,
  input  wire logic [31:0]                  I_WR_VALUE,
  input  wire logic                         I_CHG_SPEED,
  input  wire logic                         I_PERSIST,
  output logic                              O_WR_REJECT,
  // Nonvolatile storage
  input  wire vprf_pkg::vprf_nv_s           I_NV_IMAGE,
  output logic                              O_NV_WR,
  output logic [1:0]                        O_NV_MASK,
  output vprf_pkg::vprf_nv_s                O_NV_IMAGE,
  // Motion
  input  wire logic                         I_MOVE_START,
  input  wire logic                         I_MOVE_DIR,
  input  wire logic                         I_MOVE_STOP,
  input  wire logic                         I_LINKED,
  input  wire logic [1:0]                   I_SEG_SEL,
  input  wire logic [vprf_pkg::TIME_W-1:0]  I_ACCEL_TIME,
  input  wire logic [vprf_pkg::TIME_W-1:0]  I_DECEL_TIME,
  output logic signed [vprf_pkg::VEL_W-1:0] O_VEL_NOW,
  output logic                              O_MOVING,
  output logic                              O_DETAIL,
  // Reply requests
  input  wire logic                         I_REQ_VALID,
  input  wire vprf_pkg::vprf_req_s          I_REQ,
  output logic                              O_REQ_READY,
  input  wire logic                         I_MULTIDROP,
  input  wire logic                         I_ADDRESSED,
  // Reply characters
  output logic                              O_TX_VALID,
  output logic [7:0]                        O_TX_BYTE,
  input  wire logic                         I_TX_READY,
  // Keyboard input
  input  wire logic                         I_KEY_VALID,
  input  wire logic [7:0]                   I_KEY_BYTE,
  output logic                              O_KEY_VALID,
  output logic [7:0]                        O_KEY_BYTE
);
  import vprf_pkg::*;

  // ***********************************************************
  // Parameter store
  // ***********************************************************
  vprf_spd_t    run_spd;
  vprf_spd_t    start_spd;
  vprf_spd_t    seg_spd [NSEG];
  logic         detail;
  logic         loaded;
  logic [6:0]   saved;
  wire          in_range = (I_WR_VALUE >= 32'(SPD_MIN)) &&
                           (I_WR_VALUE <= 32'(SPD_MAX));
  wire          spd_item = (I_WR_ITEM != IT_DETAIL) &&
                           (I_WR_ITEM != IT_VNOW);
  wire          det_ok   = (I_WR_VALUE <= 32'h0000_0001);
  wire          wr_ok    = I_WR && loaded &&
                           (spd_item ? in_range :
                            (I_WR_ITEM == IT_DETAIL) && det_ok);
  wire          chg_ok   = I_CHG_SPEED && loaded && in_range;
  wire          reject   = loaded && ((I_WR && !wr_ok) ||
                                      (I_CHG_SPEED && !chg_ok));
  wire vprf_spd_t wr_spd = I_WR_VALUE[18:0];
  wire          det_wr   = wr_ok && (I_WR_ITEM == IT_DETAIL);
  wire vprf_speeds_s spd = '{run: run_spd, start: start_spd,
    seg: {seg_spd[3], seg_spd[2], seg_spd[1], seg_spd[0]}};

  always_ff @(posedge I_REF_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      loaded    <= 1'b0;
      run_spd   <= RUN_RST;
      start_spd <= START_RST;
      detail    <= DETAIL_RST;
      saved     <= 7'h00;
    end
    else if (!loaded)
    begin
      loaded    <= 1'b1;
      saved     <= I_NV_IMAGE.valid;
      if (I_NV_IMAGE.valid[IT_RUN])
        run_spd   <= I_NV_IMAGE.spd.run;
      if (I_NV_IMAGE.valid[IT_START])
        start_spd <= I_NV_IMAGE.spd.start;
      if (I_NV_IMAGE.valid[IT_DETAIL])
        detail    <= I_NV_IMAGE.detail;
    end
    else
    begin
      if (chg_ok)
        run_spd   <= wr_spd;
      else if (wr_ok && I_WR_ITEM == IT_RUN)
        run_spd   <= wr_spd;
      if (wr_ok && I_WR_ITEM == IT_START)
        start_spd <= wr_spd;
      if (det_wr)
        detail    <= I_WR_VALUE[0];
      if (I_PERSIST)
        saved     <= saved | 7'b011_1111;
      if (det_wr)
        saved     <= saved | 7'b100_0000 |
                     (I_PERSIST ? 7'b011_1111 : 7'h00);
    end
  end

  genvar s;
  generate
    for (s = 0; s < NSEG; s++)
    begin : g_seg
      wire hit = wr_ok && (I_WR_ITEM == vprf_item_e'(IT_SEG0 + 3'(s)));
      always_ff @(posedge I_REF_CLK or negedge I_RST_B)
      begin
        if (!I_RST_B)
          seg_spd[s] <= SEG_RST;
        else if (!loaded && I_NV_IMAGE.valid[IT_SEG0 + s])
          seg_spd[s] <= I_NV_IMAGE.spd.seg[s];
        else if (hit)
          seg_spd[s] <= wr_spd;
      end
    end
  endgenerate

  // Speed saves on command; detail level saves on every accepted write
  always_ff @(posedge I_REF_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      O_NV_WR     <= 1'b0;
      O_NV_MASK   <= 2'h0;
      O_NV_IMAGE  <= '0;
      O_WR_REJECT <= 1'b0;
      O_DETAIL    <= DETAIL_RST;
    end
    else
    begin
      O_NV_WR     <= loaded && (I_PERSIST || det_wr);
      O_NV_MASK   <= {det_wr, I_PERSIST && loaded};
      O_NV_IMAGE  <= '{spd: spd, detail: detail, valid: saved};
      O_WR_REJECT <= reject;
      O_DETAIL    <= detail;
    end
  end

  // ***********************************************************
  // Velocity profiler
  // ***********************************************************
  wire vprf_spd_t target = I_LINKED ? spd.seg[I_SEG_SEL] : spd.run;

  vprf_ramp #(.TICK_CYC(TICK_CYC)) u_ramp
  (
    .i_clk       (I_REF_CLK),
    .i_rst_b     (I_RST_B),
    .i_start     (I_MOVE_START && loaded),
    .i_dir       (I_MOVE_DIR),
    .i_stop      (I_MOVE_STOP),
    .i_target    (target),
    .i_start_spd (spd.start),
    .i_accel_ms  (I_ACCEL_TIME),
    .i_decel_ms  (I_DECEL_TIME),
    .o_vel       (O_VEL_NOW),
    .o_moving    (O_MOVING)
  );

  // ***********************************************************
  // Keyboard gate
  // ***********************************************************
  always_ff @(posedge I_REF_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      O_KEY_VALID <= 1'b0;
      O_KEY_BYTE  <= 8'h00;
    end
    else
    begin
      O_KEY_VALID <= I_KEY_VALID && (!I_MULTIDROP || I_ADDRESSED);
      O_KEY_BYTE  <= I_KEY_BYTE;
    end
  end

  // ***********************************************************
  // Reply formatter
  // ***********************************************************
  vprf_tx_e             state;
  vprf_tx_e             next_state;
  vprf_req_s            req;
  logic signed [VEL_W-1:0] val;
  logic [4:0]           idx;
  logic [NDIG-1:0][3:0] dig;
  logic                 neg;
  logic [2:0]           ndig;
  logic [7:0]           cur;
  wire                  adv   = !O_TX_VALID || I_TX_READY;
  wire                  quiet = I_REQ.from_seq && I_MULTIDROP &&
                                !I_ADDRESSED;
  wire                  is_seg = (req.item >= IT_SEG0) &&
                                 (req.item <= IT_SEG3);
  wire [4:0]            name_len = is_seg ? 5'h03 : 5'h02;
  wire [4:0]            val_len  = 5'(ndig) + 5'(neg);
  wire [2:0]            dpos = 3'(val_len - idx - 5'h01);
  wire [4:0]            last = (state == TX_NAME) ? name_len :
                               (state == TX_VAL) ? val_len :
                               5'(FWID_LEN);
  wire                  done = (idx == last - 5'h01);
  logic signed [VEL_W-1:0] sel_val;

  always_comb
  begin
    case (I_REQ.item)
      IT_RUN:    sel_val = $signed({1'b0, spd.run});
      IT_START:  sel_val = $signed({1'b0, spd.start});
      IT_DETAIL: sel_val = $signed(20'(detail));
      IT_VNOW:   sel_val = O_VEL_NOW;
      default:   sel_val = $signed({1'b0, spd.seg[2'(I_REQ.item - 3'h1)]});
    endcase
  end

  vprf_dec u_dec
  (
    .i_val  (val),
    .o_dig  (dig),
    .o_neg  (neg),
    .o_ndig (ndig)
  );

  always_comb
  begin
    case (state)
      TX_NAME:
        cur = (idx == 5'h00) ? CH_NAME0 :
              (idx == 5'h02) ? CH_ZERO + 8'(req.item - IT_SEG0) :
              (req.item == IT_START)  ? CH_START :
              (req.item == IT_DETAIL) ? CH_DETAIL :
              (req.item == IT_VNOW)   ? CH_VNOW : CH_RUN;
      TX_EQ:     cur = CH_EQ;
      TX_VAL:    cur = (neg && idx == 5'h00) ? CH_MINUS :
                       CH_ZERO + 8'(dig[dpos]);
      TX_CR:     cur = CH_CR;
      TX_LF:     cur = CH_LF;
      TX_PROMPT: cur = CH_PROMPT;
      TX_FWID:   cur = FW_TEXT[8*(FWID_LEN-1-32'(idx)) +: 8];
      default:   cur = 8'h00;
    endcase
  end

  always_comb
  begin
    next_state = state;
    case (state)
      TX_IDLE:
        if (I_REQ_VALID && !quiet)
          next_state = (I_REQ.kind == RQ_VERSION) ? TX_FWID :
                       (I_REQ.kind == RQ_QUERY && detail) ? TX_NAME :
                       TX_VAL;
      TX_NAME:   if (adv && done) next_state = TX_EQ;
      TX_EQ:     if (adv) next_state = TX_VAL;
      TX_VAL:
        if (adv && done)
          next_state = (req.kind == RQ_VIEW) ? TX_IDLE : TX_CR;
      TX_FWID:   if (adv && done) next_state = TX_CR;
      TX_CR:     if (adv) next_state = TX_LF;
      TX_LF:     if (adv) next_state = TX_PROMPT;
      TX_PROMPT: if (adv) next_state = TX_IDLE;
      default:   next_state = TX_IDLE;
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      state       <= TX_IDLE;
      req         <= '0;
      val         <= 20'sh0_0000;
      idx         <= 5'h00;
      O_TX_VALID  <= 1'b0;
      O_TX_BYTE   <= 8'h00;
      O_REQ_READY <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      O_REQ_READY <= loaded && (next_state == TX_IDLE);
      if (state == TX_IDLE && I_REQ_VALID)
      begin
        req <= I_REQ;
        val <= sel_val;
        idx <= 5'h00;
      end
      else if (adv && state != TX_IDLE)
      begin
        idx <= (next_state != state) ? 5'h00 : idx + 5'h01;
      end
      if (adv)
      begin
        O_TX_VALID <= (state != TX_IDLE);
        O_TX_BYTE  <= cur;
      end
    end
  end

endmodule

// ==== vprf_chk.sv ====
`timescale 1ns/10ps
module vprf_chk
  import vprf_pkg::*;
(
  input wire logic                    I_REF_CLK, I_RST_B, I_WR, I_PERSIST,
  input wire vprf_pkg::vprf_item_e    I_WR_ITEM,
  input wire logic [31:0]             I_WR_VALUE,
  input wire logic                    O_WR_REJECT, O_NV_WR, O_DETAIL,
  input wire logic [1:0]              O_NV_MASK,
  input wire logic                    I_MOVE_START, I_MOVE_DIR, O_MOVING,
  input wire logic signed [vprf_pkg::VEL_W-1:0] O_VEL_NOW,
  input wire logic                    I_REQ_VALID, O_REQ_READY, O_TX_VALID,
  input wire logic                    I_MULTIDROP, I_ADDRESSED,
  input wire vprf_pkg::vprf_req_s     I_REQ
);
  logic take;
  logic mute;
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);
  assign take = I_REQ_VALID && O_REQ_READY;
  assign mute = I_REQ.from_seq && I_MULTIDROP && !I_ADDRESSED;
  AST_DET_WR:
    assert property (I_WR && I_WR_ITEM == IT_DETAIL && I_WR_VALUE == 0
      |=> O_NV_WR && O_NV_MASK[1] ##1 !O_DETAIL) else $error("detail write");
  AST_REJ:
    assert property (I_WR && I_WR_ITEM inside {IT_RUN, IT_START} &&
      (I_WR_VALUE == 0 || I_WR_VALUE > SPD_MAX) |-> ##[1:2] O_WR_REJECT)
      else $error("bad speed taken");
  AST_SAVE:
    assert property (I_PERSIST |=> O_NV_WR && O_NV_MASK[0])
      else $error("save not issued");
  AST_START:
    assert property (I_MOVE_START && !O_MOVING |-> ##2 O_MOVING &&
      O_VEL_NOW != 0 && O_VEL_NOW[VEL_W-1] == $past(I_MOVE_DIR, 2))
      else $error("start step wrong");
  AST_IDLE:
    assert property (!O_MOVING |-> O_VEL_NOW == 0) else $error("idle speed");
  AST_BOUND:
    assert property (O_VEL_NOW <= 20'sh7_A120 && O_VEL_NOW >= -20'sh7_A120)
      else $error("speed out of bound");
  AST_REPLY:
    assert property (take && !mute |-> ##2 O_TX_VALID) else $error("no reply");
  AST_MUTE:
    assert property (take && mute |=> !O_TX_VALID [*4])
      else $error("muted reply sent");
endmodule
bind vprf_top vprf_chk i_chk (.I_REF_CLK(I_REF_CLK), .I_RST_B(I_RST_B),
  .I_WR(I_WR), .I_PERSIST(I_PERSIST), .I_WR_ITEM(I_WR_ITEM),
  .I_WR_VALUE(I_WR_VALUE), .O_WR_REJECT(O_WR_REJECT), .O_NV_WR(O_NV_WR),
  .O_DETAIL(O_DETAIL), .O_NV_MASK(O_NV_MASK), .I_MOVE_START(I_MOVE_START),
  .I_MOVE_DIR(I_MOVE_DIR), .O_MOVING(O_MOVING), .O_VEL_NOW(O_VEL_NOW),
  .I_REQ_VALID(I_REQ_VALID), .O_REQ_READY(O_REQ_READY), .I_REQ(I_REQ),
  .O_TX_VALID(O_TX_VALID), .I_MULTIDROP(I_MULTIDROP),
  .I_ADDRESSED(I_ADDRESSED));

// ==== vprf_host.sv ====
`timescale 1ns/10ps
module vprf_host
(
  input  wire logic       i_clk,
  input  wire logic       i_slow,
  input  wire logic       i_valid,
  input  wire logic [7:0] i_byte,
  output logic            o_ready
);
  logic [7:0] rx [$];
  logic [1:0] cnt = 2'h0;
  // Slow host takes one byte in four cycles
  assign o_ready = !i_slow || cnt == 2'h0;
  always @(posedge i_clk)
  begin
    cnt <= cnt + 2'h1;
    if (i_valid && o_ready)
      rx.push_back(i_byte);
  end
endmodule

// ==== test_velocity_profile_and_reply_format.sv ====
`timescale 1ns/10ps
module test_velocity_profile_and_reply_format;
  import vprf_pkg::*;
  typedef struct packed {
    logic w; vprf_item_e i; logic [31:0] v; logic [31:0] e; logic r;
  } vprf_row_s;
  logic clk = 0, rst_b = 0, wr = 0, chg = 0, per = 0, mv = 0, dir = 0;
  logic stp = 0, lnk = 0, rv = 0, md = 0, adr = 0, kv = 0, slow = 0;
  logic r, rej, mvg, det, rdy, txv, txr, kvo;
  logic [7:0] txb, kbo;
  logic signed [VEL_W-1:0] vel;
  logic [31:0] val = '0;
  vprf_item_e itm = IT_RUN;
  vprf_req_s rq = '0;
  vprf_nv_s nv = '0, nvo;
  int failures = 0, cmp_count = 0, nrx, t;
  vprf_row_s rows [11] = '{'{1, IT_DETAIL, 0, 0, 0},
    '{1, IT_DETAIL, 2, 0, 1}, '{1, IT_VNOW, 5, 0, 1},
    '{0, IT_RUN, 0, RUN_RST, 0}, '{0, IT_SEG3, 0, SEG_RST, 0},
    '{1, IT_START, 0, START_RST, 1}, '{1, IT_RUN, SPD_MAX, SPD_MAX, 0},
    '{1, IT_RUN, SPD_MAX + 1, SPD_MAX, 1}, '{1, IT_SEG0, 1, 1, 0},
    '{1, IT_SEG1, 10'h309, 10'h309, 0}, '{1, IT_SEG2, 0, SEG_RST, 1}};
  // Identification text is arbitrary
  vprf_top #(.TICK_CYC(4), .FW_TEXT("ABCDEFGHIJKLMNOPQRSTUVWX")) i_dut (
    .I_REF_CLK(clk), .I_RST_B(rst_b), .I_WR(wr), .I_WR_ITEM(itm),
    .I_WR_VALUE(val), .I_CHG_SPEED(chg), .I_PERSIST(per), .O_NV_WR(),
    .O_WR_REJECT(rej), .I_NV_IMAGE(nv), .O_NV_MASK(), .O_NV_IMAGE(nvo),
    .I_MOVE_START(mv), .I_MOVE_DIR(dir), .I_MOVE_STOP(stp), .I_LINKED(lnk),
    .I_SEG_SEL(2'h1), .I_ACCEL_TIME(16'h0004), .I_DECEL_TIME(16'h0004),
    .O_VEL_NOW(vel), .O_MOVING(mvg), .O_DETAIL(det), .I_REQ_VALID(rv),
    .I_REQ(rq), .O_REQ_READY(rdy), .I_MULTIDROP(md), .I_ADDRESSED(adr),
    .O_TX_VALID(txv), .O_TX_BYTE(txb), .I_TX_READY(txr), .I_KEY_VALID(kv),
    .I_KEY_BYTE(8'h41), .O_KEY_VALID(kvo), .O_KEY_BYTE(kbo));
  vprf_host i_host (.i_clk(clk), .i_slow(slow), .i_valid(txv),
    .i_byte(txb), .o_ready(txr));
  initial forever #10 clk = ~clk;
  function automatic logic [95:0] pk(string s);
    pk = '0;
    foreach (s[j]) pk = {pk[87:0], s[j]};
  endfunction
  task summarize;
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(string n, logic [95:0] s, logic [95:0] e);
    cmp_count++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task lim(int n);
    if (t >= n)
    begin
      failures++;
      summarize();
    end
  endtask
  task wrt(vprf_item_e i, logic [31:0] v, output logic o);
    itm = i;
    val = v;
    wr = 1;
    @(negedge clk) wr = 0;
    o = rej;
    @(negedge clk) o = o | rej;
  endtask
  task ask(vprf_kind_e k, vprf_item_e i, logic s, string x);
    logic [95:0] got;
    got = '0;
    i_host.rx.delete();
    rq = '{k, i, s};
    rv = 1;
    @(negedge clk) rv = 0;
    for (t = 0; t < 300 && (rdy !== 1'h1 || txv !== 1'h0); t++)
      @(negedge clk);
    lim(300);
    nrx = i_host.rx.size();
    foreach (i_host.rx[j]) got = {got[87:0], i_host.rx[j]};
    chk("reply", got, pk(x));
  endtask
  task move(logic d, logic l, logic signed [VEL_W-1:0] p);
    dir = d;
    lnk = l;
    mv = 1;
    @(negedge clk) mv = 0;
    @(negedge clk) chk("start", vel, d ? -20'sh64 : 20'sh64);
    for (t = 0; t < 100 && vel !== p; t++) @(negedge clk);
    lim(100);
    chk("ramp", t > 7 && t < 25, 1);
    stp = 1;
    @(negedge clk) stp = 0;
    for (t = 0; t < 100 && mvg !== 1'h0; t++) @(negedge clk);
    lim(100);
    chk("stop", vel, 0);
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    rst_b = 1;
    repeat (3) @(negedge clk);
    chk("detail", det, 1);
    foreach (rows[k])
    begin
      r = 0;
      if (rows[k].w) wrt(rows[k].i, rows[k].v, r);
      chk("reject", r, rows[k].r);
      ask(RQ_QUERY, rows[k].i, 0, {$sformatf("%0d", rows[k].e), "\r\n>"});
    end
    val = 9'h12C;
    chg = 1;
    @(negedge clk) chg = 0;
    ask(RQ_QUERY, IT_RUN, 0, "300\r\n>");
    move(1, 0, -20'sh12C);
    move(0, 1, 20'sh309);
    wrt(IT_DETAIL, 1, r);
    ask(RQ_QUERY, IT_RUN, 0,
      $sformatf("%c%c=300\r\n>", CH_NAME0, CH_RUN));
    wrt(IT_DETAIL, 0, r);
    slow = 1;
    md = 1;
    adr = 1;
    ask(RQ_VIEW, IT_SEG1, 1, "777");
    adr = 0;
    ask(RQ_VIEW, IT_SEG1, 1, "");
    kv = 1;
    @(negedge clk) kv = 0;
    chk("key", kvo, 0);
    md = 0;
    @(negedge clk) kv = 1;
    @(negedge clk) kv = 0;
    chk("key", kvo, 1);
    chk("keybyte", kbo, 8'h41);
    ask(RQ_VERSION, IT_RUN, 0, "ABCDEFGHIJKLMNOPQRSTUVWX\r\n>");
    chk("length", nrx, 27);
    per = 1;
    @(negedge clk) per = 0;
    @(negedge clk);
    chk("image", {nvo.spd.run, nvo.valid}, {19'h0_012C, 7'h7F});
    nv.spd.run = 11'h4D2;
    nv.spd.start = START_RST;
    nv.valid = 7'h21;
    rst_b = 0;
    repeat (2) @(negedge clk);
    rst_b = 1;
    repeat (3) @(negedge clk);
    chk("detail", det, 1);
    ask(RQ_QUERY, IT_RUN, 0,
      $sformatf("%c%c=1234\r\n>", CH_NAME0, CH_RUN));
    summarize();
  end
endmodule
